//--- rtl/trigger_value_latch.sv
// module: trigger value latch with four capture modes, two variants and an Avalon-MM slave
// assumes: all inputs synchronous to clk; master holds a request until waitrequest is low
`timescale 1ns/1ps
`default_nettype none

module trigger_value_latch #(
  parameter int WORD_W = trigger_value_latch_pkg::WORD_W
) (
  input  wire logic              clk,
  input  wire logic              reset,
  // avalon-mm slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // operational input sources
  input  wire logic [WORD_W-1:0] islandWord,
  input  wire logic [WORD_W-1:0] fieldbusWord,
  input  wire logic [WORD_W-1:0] blockWord,
  // trigger sources
  input  wire logic              islandTrig,
  input  wire logic              fieldbusTrig,
  input  wire logic              blockTrig,
  // results
  output logic [WORD_W-1:0]      analogOut,
  output logic                   digitalOut
);

  // ****************************************
  // configuration registers
  // ****************************************
  logic [7:0]        ctrl_r;
  logic [WORD_W-1:0] constOp_r;
  logic              constTrig_r;
  logic              ack_r;
  logic [31:0]       readData_r;
  logic              busReq;
  logic              doWrite;

  logic [1:0] mode;
  logic       isAnalog;
  logic       invert;
  logic [1:0] opSel;
  logic [1:0] trigSel;

  assign mode     = ctrl_r[trigger_value_latch_pkg::CTRL_MODE_LSB +: 2];
  assign isAnalog = ctrl_r[trigger_value_latch_pkg::CTRL_VARIANT];
  assign invert   = ctrl_r[trigger_value_latch_pkg::CTRL_INVERT];
  assign opSel    = ctrl_r[trigger_value_latch_pkg::CTRL_OPSEL_LSB +: 2];
  assign trigSel  = ctrl_r[trigger_value_latch_pkg::CTRL_TRSEL_LSB +: 2];

  // ****************************************
  // bus handshake
  // ****************************************
  // one wait cycle per request; answer on the second edge
  assign busReq          = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~ack_r;
  assign doWrite         = avs_write & ack_r;
  assign avs_readdata    = readData_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= busReq & ~ack_r;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r      <= trigger_value_latch_pkg::CTRL_RESET;
      constOp_r   <= trigger_value_latch_pkg::WORD_RESET;
      constTrig_r <= 1'b0;
    end else if (doWrite) begin
      case (avs_address)
        trigger_value_latch_pkg::OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            ctrl_r <= avs_writedata[7:0];
          end
        end
        trigger_value_latch_pkg::OFS_CONST_OP: begin
          if (avs_byteenable[0]) begin
            constOp_r[7:0] <= avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            constOp_r[WORD_W-1:8] <= avs_writedata[WORD_W-1:8];
          end
        end
        trigger_value_latch_pkg::OFS_CONST_TRG: begin
          if (avs_byteenable[0]) begin
            constTrig_r <= avs_writedata[0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // source selection
  // ****************************************
  logic [WORD_W-1:0] opSrc;
  logic [WORD_W-1:0] opWord;
  logic              trigCur;
  logic              trigPrev_r;

  always_comb begin
    case (opSel)
      trigger_value_latch_pkg::SRC_ISLAND:   opSrc = islandWord;
      trigger_value_latch_pkg::SRC_CONSTANT: opSrc = constOp_r;
      trigger_value_latch_pkg::SRC_FIELDBUS: opSrc = fieldbusWord;
      default:                               opSrc = blockWord;
    endcase
    case (trigSel)
      trigger_value_latch_pkg::SRC_ISLAND:   trigCur = islandTrig;
      trigger_value_latch_pkg::SRC_CONSTANT: trigCur = constTrig_r;
      trigger_value_latch_pkg::SRC_FIELDBUS: trigCur = fieldbusTrig;
      default:                               trigCur = blockTrig;
    endcase
  end

  // digital variant keeps only bit 0 of the operational input
  assign opWord = isAnalog ? opSrc : {{(WORD_W-1){1'b0}}, opSrc[0]};

  // ****************************************
  // capture and hold
  // ****************************************
  logic              riseEvt;
  logic              fallEvt;
  logic              holdLevel;
  logic              passThru;
  logic              capture;
  logic [WORD_W-1:0] outWord_nxt;
  logic [WORD_W-1:0] outWord_r;
  logic              digOut_r;

  assign riseEvt = trigCur & ~trigPrev_r;
  assign fallEvt = ~trigCur & trigPrev_r;
  // level modes hold at the selected trigger level
  assign holdLevel = (mode == trigger_value_latch_pkg::MODE_LOW)  ? ~trigCur :
                     (mode == trigger_value_latch_pkg::MODE_HIGH) ?  trigCur :
                     1'b1;
  assign passThru = ~holdLevel;

  always_comb begin
    case (mode)
      trigger_value_latch_pkg::MODE_FALL: capture = fallEvt;
      trigger_value_latch_pkg::MODE_RISE: capture = riseEvt;
      trigger_value_latch_pkg::MODE_LOW:  capture = fallEvt;
      default:                            capture = riseEvt;
    endcase
  end

  // input sampled at capture or while passThru; otherwise unchanged until next event
  assign outWord_nxt = (capture | passThru) ? opWord : outWord_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trigPrev_r <= 1'b0;
    end else begin
      trigPrev_r <= trigCur;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      outWord_r <= trigger_value_latch_pkg::WORD_RESET;
    end else begin
      outWord_r <= outWord_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      digOut_r <= 1'b0;
    end else begin
      digOut_r <= outWord_nxt[0] ^ (invert & ~isAnalog);
    end
  end

  assign analogOut  = outWord_r;
  assign digitalOut = digOut_r;

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readData_r <= 32'h0000_0000;
    end else if (avs_read & ~ack_r) begin
      readData_r <= 32'h0000_0000;
      case (avs_address)
        trigger_value_latch_pkg::OFS_CTRL:      readData_r[7:0] <= ctrl_r;
        trigger_value_latch_pkg::OFS_CONST_OP:  readData_r[WORD_W-1:0] <= constOp_r;
        trigger_value_latch_pkg::OFS_CONST_TRG: readData_r[0] <= constTrig_r;
        trigger_value_latch_pkg::OFS_STATUS: begin
          readData_r[WORD_W-1:0] <= outWord_r;
          readData_r[trigger_value_latch_pkg::STAT_DIG_OUT] <= digOut_r;
          readData_r[trigger_value_latch_pkg::STAT_HOLDING] <= holdLevel;
          readData_r[trigger_value_latch_pkg::STAT_TRIGGER] <= trigCur;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_FALL_CAPTURE: assert property (
    @(posedge clk) disable iff (reset)
    (mode == trigger_value_latch_pkg::MODE_FALL && !trigCur && trigPrev_r)
      |=> (analogOut == $past(opWord)))
    else $error("falling edge did not capture input");

  AST_RISE_CAPTURE: assert property (
    @(posedge clk) disable iff (reset)
    (mode == trigger_value_latch_pkg::MODE_RISE && trigCur && !trigPrev_r)
      |=> (analogOut == $past(opWord)))
    else $error("rising edge did not capture input");

  AST_LOW_HOLD: assert property (
    @(posedge clk) disable iff (reset)
    (mode == trigger_value_latch_pkg::MODE_LOW && !trigCur && !trigPrev_r)
      |=> (analogOut == $past(analogOut)))
    else $error("low level latch did not hold");

  AST_HIGH_HOLD: assert property (
    @(posedge clk) disable iff (reset)
    (mode == trigger_value_latch_pkg::MODE_HIGH && trigCur && trigPrev_r)
      |=> (analogOut == $past(analogOut)))
    else $error("high level latch did not hold");

  AST_PASS_THRU: assert property (
    @(posedge clk) disable iff (reset)
    ((mode == trigger_value_latch_pkg::MODE_LOW && trigCur) ||
     (mode == trigger_value_latch_pkg::MODE_HIGH && !trigCur))
      |=> (analogOut == $past(opWord)))
    else $error("released output did not follow input");

  AST_SAMPLED_VALUE: assert property (
    @(posedge clk) disable iff (reset)
    (capture && !passThru) ##1 (!capture && !passThru && $stable(ctrl_r))
      |-> (analogOut == $past(opWord)))
    else $error("held value is not the captured sample");

  AST_EDGE_HOLD: assert property (
    @(posedge clk) disable iff (reset)
    (mode[1] == 1'b0 && !capture) |=> $stable(analogOut))
    else $error("edge latch output changed without trigger event");

  AST_INVERT: assert property (
    @(posedge clk) disable iff (reset)
    (!isAnalog && invert) |=> (digitalOut == !analogOut[0]))
    else $error("inverted digital output wrong");

  AST_NO_INVERT: assert property (
    @(posedge clk) disable iff (reset)
    (isAnalog || !invert) |=> (digitalOut == analogOut[0]))
    else $error("output inverted when it must not be");

  AST_DIGITAL_WIDTH: assert property (
    @(posedge clk) disable iff (reset)
    (!isAnalog && (capture || passThru)) |=> (analogOut[WORD_W-1:1] == '0))
    else $error("digital variant carries more than one bit");

  AST_CONST_SOURCE: assert property (
    @(posedge clk) disable iff (reset)
    (opSel == trigger_value_latch_pkg::SRC_CONSTANT && isAnalog) |-> (opWord == constOp_r))
    else $error("constant source not selected");

  AST_RESET_CLEAR: assert property (
    @(posedge clk)
    $fell(reset) |-> (analogOut == '0 && digitalOut == 1'b0))
    else $error("output not cleared by reset");

  AST_BUS_ANSWER: assert property (
    @(posedge clk) disable iff (reset)
    (busReq && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer later than one wait cycle");

  AST_CTRL_WRITE: assert property (
    @(posedge clk) disable iff (reset)
    (doWrite && avs_address == trigger_value_latch_pkg::OFS_CTRL && avs_byteenable[0])
      |=> (ctrl_r == $past(avs_writedata[7:0])))
    else $error("control write did not land");

  AST_TRIG_WRITE: assert property (
    @(posedge clk) disable iff (reset)
    (doWrite && avs_address == trigger_value_latch_pkg::OFS_CONST_TRG && avs_byteenable[0])
      |=> (constTrig_r == $past(avs_writedata[0])))
    else $error("constant trigger write did not land");

  AST_LANE_MASK: assert property (
    @(posedge clk) disable iff (reset)
    (doWrite && avs_address == trigger_value_latch_pkg::OFS_CONST_OP && !avs_byteenable[0])
      |=> (constOp_r[7:0] == $past(constOp_r[7:0])))
    else $error("disabled byte lane was written");

  AST_UNMAPPED_READ: assert property (
    @(posedge clk) disable iff (reset)
    (avs_read && !ack_r && avs_address[1:0] != 2'h0) |=> (readData_r == 32'h0000_0000))
    else $error("unmapped read returned data");

  AST_STATUS_READ: assert property (
    @(posedge clk) disable iff (reset)
    (avs_read && !ack_r && avs_address == trigger_value_latch_pkg::OFS_STATUS)
      |=> (avs_readdata[WORD_W-1:0] == $past(outWord_r) &&
           avs_readdata[trigger_value_latch_pkg::STAT_TRIGGER] == $past(trigCur)))
    else $error("status read does not show output and trigger");

  AST_ANALOG_WORD: assert property (
    @(posedge clk) disable iff (reset)
    (isAnalog && (capture || passThru))
      |=> (analogOut == $past(opSrc)))
    else $error("analog word not loaded whole");

  AST_DIGITAL_BIT: assert property (
    @(posedge clk) disable iff (reset)
    (!isAnalog && !invert && (capture || passThru))
      |=> (digitalOut == $past(opSrc[0])))
    else $error("digital output does not carry bit 0");

  AST_TRIG_SOURCE: assert property (
    @(posedge clk) disable iff (reset)
    (trigSel == trigger_value_latch_pkg::SRC_CONSTANT) |-> (trigCur == constTrig_r))
    else $error("constant trigger not selected");

  AST_WAIT_FIRST: assert property (
    @(posedge clk) disable iff (reset)
    ($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest)
    else $error("new request answered without a wait cycle");

endmodule : trigger_value_latch

`default_nettype wire

//--- rtl/trigger_value_latch_pkg.sv
// package: register map, field layout, reset values and codes of the trigger value latch
// assumes: a 32-bit Avalon-MM slave port with byte addresses; one 250 MHz clock
//
// Functional notes
// - In falling-edge mode the operational input is captured when the trigger goes from 1 to 0.
// - In rising-edge mode the operational input is captured when the trigger goes from 0 to 1.
// - In low-level mode the output holds the captured value while the trigger is 0.
// - In high-level mode the output holds the captured value while the trigger is 1.
// - Whenever the output is not held it follows the operational input.
// - The output equals the input as sampled at capture, not any later input value.
// - After a capture the output stays unchanged until the next qualifying trigger event; level modes follow the input once the trigger leaves the hold level.
// - A digital variant works on one bit and an analog variant works on a word.
// - The digital variant has an option that inverts its output.
// - The analog variant has no inversion, its word is always the held or passed value.
// - With inversion selected the digital output shows 1 for 0 and 0 for 1.
// - Each input comes from an island module, a constant, the fieldbus master or another block.
`default_nettype none

package trigger_value_latch_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [3:0] OFS_CTRL      = 4'h0;
  localparam logic [3:0] OFS_CONST_OP  = 4'h4;
  localparam logic [3:0] OFS_CONST_TRG = 4'h8;
  localparam logic [3:0] OFS_STATUS    = 4'hC;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_VARIANT   = 2;
  localparam int CTRL_INVERT    = 3;
  localparam int CTRL_OPSEL_LSB = 4;
  localparam int CTRL_TRSEL_LSB = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ****************************************
  // status register fields
  // ****************************************
  localparam int STAT_DIG_OUT = 16;
  localparam int STAT_HOLDING = 17;
  localparam int STAT_TRIGGER = 18;

  // ****************************************
  // capture modes and input sources
  // ****************************************
  localparam logic [1:0] MODE_FALL = 2'h0;
  localparam logic [1:0] MODE_RISE = 2'h1;
  localparam logic [1:0] MODE_LOW  = 2'h2;
  localparam logic [1:0] MODE_HIGH = 2'h3;

  localparam logic [1:0] SRC_ISLAND   = 2'h0;
  localparam logic [1:0] SRC_CONSTANT = 2'h1;
  localparam logic [1:0] SRC_FIELDBUS = 2'h2;
  localparam logic [1:0] SRC_BLOCK    = 2'h3;

  localparam int          WORD_W     = 16;
  localparam logic [15:0] WORD_RESET = 16'h0000;

endpackage : trigger_value_latch_pkg

`default_nettype wire

//--- dv/source_model.sv
// file: behavioural data sources at the far side of the latch
// assumes: bench sets word and trig right after a rising clk edge
`timescale 1ns/1ps
`default_nettype none

module source_model (
  input  wire logic [15:0] word,
  input  wire logic        trig,
  output logic      [15:0] islandWord,
  output logic      [15:0] fieldbusWord,
  output logic      [15:0] blockWord,
  output logic             islandTrig,
  output logic             fieldbusTrig,
  output logic             blockTrig
);
  // each source word shows its own view, so a wrong select is seen; islandTrig and blockTrig are equal
  assign islandWord   = word;
  assign fieldbusWord = ~word;
  assign blockWord    = {word[7:0], word[15:8]};
  assign islandTrig   = trig;
  assign fieldbusTrig = ~trig;
  assign blockTrig    = trig;
endmodule : source_model

`default_nettype wire

//--- dv/tb.sv
// file: self-checking bench of the trigger value latch
// assumes: package, design and source_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clk;
  logic        reset;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] word;
  logic        trig;
  logic [15:0] islandWord, fieldbusWord, blockWord, analogOut;
  logic        islandTrig, fieldbusTrig, blockTrig, digitalOut;
  logic        isDig;
  int          n_fail;
  int          cmp_count;

  trigger_value_latch i_trigger_value_latch (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .islandWord(islandWord), .fieldbusWord(fieldbusWord), .blockWord(blockWord),
    .islandTrig(islandTrig), .fieldbusTrig(fieldbusTrig), .blockTrig(blockTrig),
    .analogOut(analogOut), .digitalOut(digitalOut));

  source_model i_source_model (.word(word), .trig(trig), .islandWord(islandWord),
    .fieldbusWord(fieldbusWord), .blockWord(blockWord), .islandTrig(islandTrig),
    .fieldbusTrig(fieldbusTrig), .blockTrig(blockTrig));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] dat,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    @(posedge clk);
    avs_address    <= adr;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= dat;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      test_done();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [3:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    bus(1'b1, adr, dat, 4'hF, rd);
  endtask : wreg

  function automatic logic [31:0] ctrl(input logic [1:0] m, input logic an,
                                       input logic inv, input logic [1:0] s);
    return {24'h00_0000, s, s, inv, an, m};
  endfunction : ctrl

  task automatic look(input logic [15:0] exp, input bit on);
    repeat (2) @(posedge clk);
    #1;
    if (on) begin
      chk(isDig ? {31'h0000_0000, digitalOut} : {16'h0000, analogOut}, {16'h0000, exp});
    end
  endtask : look

  task automatic step(input logic [15:0] w, input logic t, input logic [15:0] exp,
                      input bit on);
    @(posedge clk);
    word <= w;
    trig <= t;
    look(exp, on);
  endtask : step

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset;
    logic [31:0] rd;
    chk({16'h0000, analogOut}, 32'h0000_0000);
    bus(1'b0, trigger_value_latch_pkg::OFS_STATUS, 32'h0000_0000, 4'hF, rd);
    chk(rd, 32'h0002_0000);
    bus(1'b0, trigger_value_latch_pkg::OFS_CTRL, 32'h0000_0000, 4'hF, rd);
    chk(rd, 32'h0000_0000);
    bus(1'b0, 4'h2, 32'h0000_0000, 4'hF, rd);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
  endtask : test_reset

  task automatic test_edges;
    logic a;
    for (int i = 0; i < 2; i++) begin
      a = (i == 1);
      wreg(trigger_value_latch_pkg::OFS_CTRL, ctrl(a ? trigger_value_latch_pkg::MODE_RISE
        : trigger_value_latch_pkg::MODE_FALL, 1'b1, 1'b1, trigger_value_latch_pkg::SRC_ISLAND));
      step(16'h1111, !a, 16'h0000, 0);
      step(16'h2222, a, 16'h2222, 1);
      step(16'h3333, a, 16'h2222, 1);
      step(16'h4444, !a, 16'h2222, 1);
      step(16'h5555, a, 16'h5555, 1);
    end
    $display("test edges done");
  endtask : test_edges

  task automatic test_levels;
    logic h;
    for (int i = 0; i < 2; i++) begin
      h = (i == 1);
      wreg(trigger_value_latch_pkg::OFS_CTRL, ctrl(h ? trigger_value_latch_pkg::MODE_HIGH
        : trigger_value_latch_pkg::MODE_LOW, 1'b1, 1'b0, trigger_value_latch_pkg::SRC_ISLAND));
      step(16'h0101, !h, 16'h0101, 1);
      step(16'h0202, !h, 16'h0202, 1);
      step(16'h0303, h, 16'h0303, 1);
      step(16'h0404, h, 16'h0303, 1);
      step(16'h0505, !h, 16'h0505, 1);
    end
    $display("test levels done");
  endtask : test_levels

  task automatic test_digital;
    isDig = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wreg(trigger_value_latch_pkg::OFS_CTRL, ctrl(trigger_value_latch_pkg::MODE_RISE,
        1'b0, i[0], trigger_value_latch_pkg::SRC_ISLAND));
      step(16'h0000, 1'b0, 16'h0000, 0);
      step(16'h0001, 1'b1, {15'h0000, !i[0]}, 1);
      step(16'h0000, 1'b1, {15'h0000, !i[0]}, 1);
      step(16'h0000, 1'b0, {15'h0000, !i[0]}, 0);
      step(16'hFFFE, 1'b1, {15'h0000, i[0]}, 1);
    end
    isDig = 1'b0;
    $display("test digital done");
  endtask : test_digital

  task automatic test_sources;
    logic [1:0]  srcs [3];
    logic [15:0] v [3];
    logic [31:0] rd;
    logic        f;
    srcs = '{trigger_value_latch_pkg::SRC_ISLAND, trigger_value_latch_pkg::SRC_FIELDBUS,
             trigger_value_latch_pkg::SRC_BLOCK};
    for (int i = 0; i < 3; i++) begin
      f = (srcs[i] == trigger_value_latch_pkg::SRC_FIELDBUS);
      if (i == 0) begin
        v = '{16'h1234, 16'h5678, 16'h9ABC};
      end else if (i == 1) begin
        v = '{16'hEDCB, 16'hA987, 16'h6543};
      end else begin
        v = '{16'h3412, 16'h7856, 16'hBC9A};
      end
      wreg(trigger_value_latch_pkg::OFS_CTRL, ctrl(trigger_value_latch_pkg::MODE_HIGH,
        1'b1, 1'b0, srcs[i]));
      step(16'h1234, f, v[0], 1);
      step(16'h5678, !f, v[1], 1);
      step(16'h9ABC, !f, v[1], 1);
    end
    wreg(trigger_value_latch_pkg::OFS_CONST_TRG, 32'h0000_0000);
    wreg(trigger_value_latch_pkg::OFS_CONST_OP, 32'h0000_A5C3);
    bus(1'b1, trigger_value_latch_pkg::OFS_CONST_OP, 32'h0000_7E7E, 4'h2, rd);
    wreg(trigger_value_latch_pkg::OFS_CTRL, ctrl(trigger_value_latch_pkg::MODE_HIGH,
      1'b1, 1'b0, trigger_value_latch_pkg::SRC_CONSTANT));
    look(16'h7EC3, 1);
    wreg(trigger_value_latch_pkg::OFS_CONST_TRG, 32'h0000_0001);
    wreg(trigger_value_latch_pkg::OFS_CONST_OP, 32'h0000_1111);
    look(16'h7EC3, 1);
    bus(1'b0, trigger_value_latch_pkg::OFS_CONST_OP, 32'h0000_0000, 4'hF, rd);
    chk(rd, 32'h0000_1111);
    $display("test sources done");
  endtask : test_sources

  initial begin
    n_fail         = 0;
    cmp_count      = 0;
    reset          = 1'b1;
    word           = 16'h0000;
    trig           = 1'b0;
    isDig          = 1'b0;
    avs_address    = 4'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    test_reset();
    test_edges();
    test_levels();
    test_digital();
    test_sources();
    test_done();
  end
endmodule : tb

`default_nettype wire
